// *** sffrd_decoder.sv ***
// Fast read command decoder of a serial flash, link and memory side
`timescale 1ns/1ps
`include "sffrd_cfg.svh"

// Function
// R1 - Single fast read in SPI mode: eight dummy clocks after address.
// R2 - Host ignores the data line during dummy clocks.
// R3 - Quad command fast read dummies from field: 2 to 16, default 2.
// R4 - Double-rate fast read: both edges, six dummy clocks in SPI mode.
// R5 - Quad command double-rate dummies from field, at least 8, default 8.
// R6 - Quad command double-rate read never wraps.
// R7 - Forced four-byte fast read takes 32-bit address, SPI mode only.
// R8 - In quad command mode that opcode means wrapped burst read.
// R9 - Dual output: single-line address, eight dummies, data on IO0 and IO1.
// R10 - Host releases IO0 before first data falling edge in dual reads.
// R11 - Forced four-byte dual output: 32-bit address, SPI mode only.
// R12 - Quad output accepted only with quad enable set; eight dummies, four lanes.
// R13 - Host releases IO lines before first data falling edge in quad reads.
// R14 - Forced four-byte quad output: 32-bit address, SPI mode only.
// R15 - Dual I/O: address two bits per clock, four dummy clocks.
// R16 - Dual I/O captures mode byte after address; low nibble ignored.
// R17 - Mode bits 5:4 equal 10: next dual I/O read skips opcode.
// R18 - Any other mode bits value: next cycle expects a full opcode.
// R19 - Host leaves continuous mode with sixteen clocks of ones on IO0.
// R20 - Plain opcodes: 24-bit address, or 32 bits in four-byte mode.
// R21 - Reads issued while busy are ignored; a wrapped burst read while busy still pulses o_wrap_burst_cmd.
// R22 - Bits latched on rising edges; data out MSB first on falling edges.
// R23 - Address increments after each byte; stream runs until chip select rises.
// R24 - Three-byte mode takes address bits 31:24 from extended address byte.
// R25 - Chip select high ends read, releases lines, awaits next instruction.
// R26 - Double-rate reads sample and drive on both clock edges.
module sffrd_decoder
  import sffrd_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_quad_enable,
  input wire logic i_qpi_mode,
  input wire logic i_four_byte_mode,
  input wire logic [7:0] i_ext_addr,
  input wire logic [2:0] i_read_param,
  input wire logic i_busy,
  input wire logic [7:0] i_mem_data,
  output logic [31:0] o_mem_addr,
  output logic o_mem_rd,
  output logic o_wrap_burst_cmd,
  input wire logic i_spi_clk,
  input wire logic i_cs_n,
  input wire logic [3:0] i_io_in,
  output logic [3:0] o_io_out,
  output logic [3:0] o_io_oe,
  output logic [3:0] o_io_rise_out,
  output logic [3:0] o_io_rise_oe,
  output logic o_ddr_active
);

  // ============================================================
  // Helpers
  function automatic logic [31:0] shift_in(input logic [31:0] sr, input logic [3:0] v, input logic [2:0] l);
    logic [31:0] r;
    r = {sr[30:0], v[0]};
    if (l == 3'h2)
    begin
      r = {sr[29:0], v[1:0]};
    end
    else if (l == 3'h4)
    begin
      r = {sr[27:0], v};
    end
    return r;
  endfunction : shift_in

  // Single line data leaves on IO1, dual on IO1:IO0
  function automatic logic [3:0] lane_grp(input logic [7:0] b, input logic [2:0] l);
    logic [3:0] g;
    g = {2'h0, b[7], 1'h0};
    if (l == 3'h2)
    begin
      g = {2'h0, b[7:6]};
    end
    else if (l == 3'h4)
    begin
      g = b[7:4];
    end
    return g;
  endfunction : lane_grp

  function automatic logic [3:0] lane_oe(input logic [2:0] l);
    logic [3:0] e;
    e = `SFFRD_OE_X1;
    if (l == 3'h2)
    begin
      e = `SFFRD_OE_X2;
    end
    else if (l == 3'h4)
    begin
      e = `SFFRD_OE_X4;
    end
    return e;
  endfunction : lane_oe

  function automatic sffrd_dec_type op_decode(input logic [7:0] cmd, input sffrd_cfg_type cfg);
    sffrd_dec_type d;
    logic [4:0] dq;
    d = '0;
    d.op.lanes_in = 3'h1;
    d.op.lanes_out = 3'h1;
    // R20 address size follows mode
    d.op.aw32 = cfg.four_byte;
    d.op.dummy = `SFFRD_DUMMY_FAST;
    dq = {1'h0, cfg.read_param, 1'h0} + `SFFRD_DUMMY_QPI_BASE;
    if (cfg.quad_command_mode)
    begin
      d.op.lanes_in = 3'h4;
      d.op.lanes_out = 3'h4;
      if (cmd == `SFFRD_OP_FAST_READ)
      begin
        // R3 dummy from field
        d.valid = 1'h1;
        d.op.dummy = dq;
      end
      else if (cmd == `SFFRD_OP_DTR_READ)
      begin
        // R5 R6 floor of eight, no wrap
        d.valid = 1'h1;
        d.op.ddr = 1'h1;
        d.op.dummy = (dq < `SFFRD_DUMMY_QPI_DTR_MIN) ? `SFFRD_DUMMY_QPI_DTR_MIN : dq;
      end
      else if (cmd == `SFFRD_OP_FAST_READ4)
      begin
        // R8 wrapped burst instead
        d.wrap = 1'h1;
      end
    end
    else
    begin
      case (cmd)
        // R1 eight dummies
        `SFFRD_OP_FAST_READ: d.valid = 1'h1;
        `SFFRD_OP_DTR_READ:
        begin
          // R4 R26 double rate
          d.valid = 1'h1;
          d.op.ddr = 1'h1;
          d.op.dummy = `SFFRD_DUMMY_DTR;
        end
        `SFFRD_OP_FAST_READ4:
        begin
          // R7 forced 32-bit
          d.valid = 1'h1;
          d.op.aw32 = 1'h1;
        end
        `SFFRD_OP_DUAL_OUT:
        begin
          // R9 two output lanes
          d.valid = 1'h1;
          d.op.lanes_out = 3'h2;
        end
        `SFFRD_OP_DUAL_OUT4:
        begin
          // R11 forced 32-bit
          d.valid = 1'h1;
          d.op.lanes_out = 3'h2;
          d.op.aw32 = 1'h1;
        end
        `SFFRD_OP_QUAD_OUT:
        begin
          // R12 needs quad enable
          d.valid = cfg.quad_enable;
          d.op.lanes_out = 3'h4;
        end
        `SFFRD_OP_QUAD_OUT4:
        begin
          // R14 forced 32-bit
          d.valid = cfg.quad_enable;
          d.op.lanes_out = 3'h4;
          d.op.aw32 = 1'h1;
        end
        `SFFRD_OP_DUAL_IO:
        begin
          // R15 mode clocks serve as dummies
          d.valid = 1'h1;
          d.op.lanes_in = 3'h2;
          d.op.lanes_out = 3'h2;
          d.op.has_mode = 1'h1;
          d.op.dummy = `SFFRD_DUMMY_DUAL_IO;
        end
        default: d.valid = 1'h0;
      endcase
    end
    return d;
  endfunction : op_decode

  // ============================================================
  // Crossings
  sffrd_cfg_type cfg_raw;
  sffrd_cfg_type cfg_l;
  logic [$bits(sffrd_cfg_type)-1:0] cfg_bits;
  logic [2:0] tgl_s;
  sffrd_xfer_type xf_ff;
  sffrd_xfer_type nxt_xf;
  sffrd_pers_type pr_ff;
  sffrd_pers_type nxt_pr;
  sffrd_fall_type fl_ff;
  sffrd_sys_type sy_ff;
  sffrd_sys_type nxt_sy;

  // Quasi-static settings, sampled by the link clock
  assign cfg_raw = '{quad_enable: i_quad_enable, quad_command_mode: i_qpi_mode, four_byte: i_four_byte_mode,
                     ext_addr: i_ext_addr, read_param: i_read_param, busy: i_busy, rst_n: i_rst_n};
  assign cfg_l = cfg_bits;

  sffrd_sync #(.WIDTH($bits(sffrd_cfg_type))) u_cfg_sync (
    .i_clk(i_spi_clk),
    .i_async(cfg_raw),
    .o_sync(cfg_bits)
  );

  sffrd_sync #(.WIDTH(3)) u_tgl_sync (
    .i_clk(i_sys_clk),
    .i_async({pr_ff.start_tgl, pr_ff.next_tgl, pr_ff.wrap_tgl}),
    .o_sync(tgl_s)
  );

  // ============================================================
  // Link rising edge logic
  always_comb
  begin
    sffrd_op_type l_op;
    sffrd_dec_type dec;
    logic [31:0] sr;
    logic [31:0] full;
    logic [5:0] c;
    logic [5:0] aw;
    logic [4:0] dum;
    logic [7:0] msr;
    logic [7:0] src;
    logic [7:0] s1;
    logic [3:0] bl;
    logic [2:0] lin_cmd;
    logic in_addr;
    logic done;
    logic to_data;
    logic emit;
    l_op = xf_ff.op;
    dec = '0;
    sr = xf_ff.addr;
    full = '0;
    c = xf_ff.cnt;
    aw = `SFFRD_ADDR_BITS_3B;
    dum = 5'h00;
    msr = 8'h00;
    src = 8'h00;
    s1 = 8'h00;
    bl = 4'h0;
    lin_cmd = cfg_l.quad_command_mode ? 3'h4 : 3'h1;
    in_addr = 1'h0;
    done = 1'h0;
    to_data = 1'h0;
    emit = 1'h0;
    nxt_xf = xf_ff;
    nxt_pr = pr_ff;
    nxt_xf.rise_out = 4'h0;
    nxt_xf.rise_oe = 4'h0;
    nxt_xf.fall_out = 4'h0;
    nxt_xf.fall_oe = 4'h0;
    case (xf_ff.state)
      LNK_CMD:
      begin
        if (pr_ff.cont && !cfg_l.quad_command_mode && (xf_ff.cnt == 6'h00))
        begin
          // R17 opcode skipped
          dec = op_decode(`SFFRD_OP_DUAL_IO, cfg_l);
          l_op = dec.op;
          nxt_xf.op = dec.op;
          // R21 busy ignores
          if (cfg_l.busy)
          begin
            nxt_xf.state = LNK_IGNORE;
          end
          else
          begin
            in_addr = 1'h1;
          end
        end
        else
        begin
          // R22 rising edge capture
          sr = shift_in(xf_ff.addr, i_io_in, lin_cmd);
          c = xf_ff.cnt + {3'h0, lin_cmd};
          nxt_xf.addr = sr;
          nxt_xf.cnt = c;
          if (c == `SFFRD_CMD_BITS)
          begin
            dec = op_decode(sr[7:0], cfg_l);
            nxt_xf.op = dec.op;
            nxt_xf.addr = 32'h0000_0000;
            nxt_xf.cnt = 6'h00;
            if (dec.wrap)
            begin
              // R8 handed to the burst path
              nxt_pr.wrap_tgl = ~pr_ff.wrap_tgl;
              nxt_xf.state = LNK_IGNORE;
            end
            // R21 busy ignores
            else if (!dec.valid || cfg_l.busy)
            begin
              nxt_xf.state = LNK_IGNORE;
            end
            else
            begin
              nxt_xf.state = LNK_ADDR;
            end
          end
        end
      end
      LNK_ADDR: in_addr = 1'h1;
      LNK_MODE:
      begin
        // R16 mode byte capture
        msr = 8'(shift_in({24'h00_0000, xf_ff.mode}, i_io_in, l_op.lanes_in));
        c = xf_ff.cnt + {3'h0, l_op.lanes_in};
        nxt_xf.mode = msr;
        nxt_xf.cnt = c;
        if (c == `SFFRD_MODE_BITS)
        begin
          // R17 R18 only bits 5:4 decide
          nxt_pr.cont = (msr[5:4] == `SFFRD_MODE_BYPASS);
          if (xf_ff.dummy == 5'h00)
          begin
            to_data = 1'h1;
          end
          else
          begin
            nxt_xf.state = LNK_DUMMY;
          end
        end
      end
      LNK_DUMMY:
      begin
        // R1 R9 R12 dummy countdown
        if (xf_ff.dummy <= 5'h01)
        begin
          to_data = 1'h1;
        end
        else
        begin
          nxt_xf.dummy = xf_ff.dummy - 5'h01;
        end
      end
      default: nxt_xf.state = xf_ff.state;
    endcase

    if (in_addr)
    begin
      aw = l_op.aw32 ? `SFFRD_ADDR_BITS_4B : `SFFRD_ADDR_BITS_3B;
      sr = xf_ff.addr;
      c = xf_ff.cnt;
      dum = l_op.dummy;
      // R26 falling half of the previous clock
      if (l_op.ddr && (c != 6'h00))
      begin
        sr = shift_in(sr, fl_ff.neg_in, l_op.lanes_in);
        c = c + {3'h0, l_op.lanes_in};
      end
      if (c == aw)
      begin
        // This clock already counts as a dummy
        done = 1'h1;
        dum = (dum != 5'h00) ? dum - 5'h01 : dum;
      end
      else
      begin
        sr = shift_in(sr, i_io_in, l_op.lanes_in);
        c = c + {3'h0, l_op.lanes_in};
        done = (c == aw);
      end
      if (done)
      begin
        // R24 R20 upper byte source
        full = l_op.aw32 ? sr : {cfg_l.ext_addr, sr[23:0]};
        nxt_pr.addr_hold = full;
        nxt_pr.start_tgl = ~pr_ff.start_tgl;
        nxt_xf.addr = full;
        nxt_xf.cnt = 6'h00;
        nxt_xf.dummy = dum;
        if (l_op.has_mode)
        begin
          nxt_xf.state = LNK_MODE;
        end
        else if (dum == 5'h00)
        begin
          to_data = 1'h1;
        end
        else
        begin
          nxt_xf.state = LNK_DUMMY;
        end
      end
      else
      begin
        nxt_xf.state = LNK_ADDR;
        nxt_xf.addr = sr;
        nxt_xf.cnt = c;
      end
    end

    if (to_data)
    begin
      nxt_xf.state = LNK_DATA;
    end
    // Single rate data starts on the falling edge of the last dummy
    emit = (to_data && !l_op.ddr) || (xf_ff.state == LNK_DATA);
    if (emit)
    begin
      bl = xf_ff.bits_left;
      src = xf_ff.byte_sr;
      if (bl == 4'h0)
      begin
        // R23 next byte requested
        src = sy_ff.data;
        bl = `SFFRD_BYTE_BITS;
        nxt_pr.next_tgl = ~pr_ff.next_tgl;
      end
      s1 = src;
      if (l_op.ddr)
      begin
        // R26 rising edge group
        nxt_xf.rise_out = lane_grp(src, l_op.lanes_out);
        nxt_xf.rise_oe = lane_oe(l_op.lanes_out);
        s1 = src << l_op.lanes_out;
        bl = bl - {1'h0, l_op.lanes_out};
      end
      // R22 MSB first on falling edge
      nxt_xf.fall_out = lane_grp(s1, l_op.lanes_out);
      nxt_xf.fall_oe = lane_oe(l_op.lanes_out);
      nxt_xf.byte_sr = s1 << l_op.lanes_out;
      nxt_xf.bits_left = bl - {1'h0, l_op.lanes_out};
    end
    nxt_xf.ddr_active = (nxt_xf.state == LNK_DATA) && l_op.ddr;
  end

  // R25 chip select high ends the transfer
  always_ff @(posedge i_spi_clk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      xf_ff <= '0;
      xf_ff.state <= LNK_CMD;
    end
    else
    begin
      xf_ff <= nxt_xf;
    end
  end

  // Survives chip select; the clock may stop between frames
  always_ff @(posedge i_spi_clk)
  begin
    if (!cfg_l.rst_n)
    begin
      pr_ff <= '0;
    end
    else
    begin
      pr_ff <= nxt_pr;
    end
  end

  // ============================================================
  // Link falling edge logic
  // R25 lines released at once
  always_ff @(negedge i_spi_clk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      fl_ff <= '0;
    end
    else
    begin
      fl_ff <= '{io_out: xf_ff.fall_out, io_oe: xf_ff.fall_oe, neg_in: i_io_in};
    end
  end

  // ============================================================
  // Memory fetch, system clock
  always_comb
  begin
    nxt_sy = sy_ff;
    nxt_sy.tgl_seen = tgl_s;
    nxt_sy.mem_rd = 1'h0;
    nxt_sy.cap = sy_ff.mem_rd;
    nxt_sy.wrap_pulse = tgl_s[0] ^ sy_ff.tgl_seen[0];
    if (tgl_s[2] ^ sy_ff.tgl_seen[2])
    begin
      nxt_sy.mem_addr = pr_ff.addr_hold;
      nxt_sy.mem_rd = 1'h1;
    end
    else if (tgl_s[1] ^ sy_ff.tgl_seen[1])
    begin
      // R23 address increment
      nxt_sy.mem_addr = sy_ff.mem_addr + 32'h0000_0001;
      nxt_sy.mem_rd = 1'h1;
    end
    if (sy_ff.cap)
    begin
      nxt_sy.data = i_mem_data;
    end
  end

  // Prefetch is far ahead of the link: a byte lasts at least one link clock
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      sy_ff <= '0;
    end
    else
    begin
      sy_ff <= nxt_sy;
    end
  end

  // ============================================================
  // Outputs
  assign o_mem_addr = sy_ff.mem_addr;
  assign o_mem_rd = sy_ff.mem_rd;
  assign o_wrap_burst_cmd = sy_ff.wrap_pulse;
  assign o_io_out = fl_ff.io_out;
  assign o_io_oe = fl_ff.io_oe;
  assign o_io_rise_out = xf_ff.rise_out;
  assign o_io_rise_oe = xf_ff.rise_oe;
  assign o_ddr_active = xf_ff.ddr_active;

endmodule : sffrd_decoder

// *** sffrd_cfg.svh ***
// Constants of the serial flash fast read decoder
`ifndef SFFRD_CFG_SVH
`define SFFRD_CFG_SVH

// ============================================================
// Opcodes
`define SFFRD_OP_FAST_READ 8'h0b
`define SFFRD_OP_DTR_READ 8'h0d
`define SFFRD_OP_FAST_READ4 8'h0c
`define SFFRD_OP_DUAL_OUT 8'h3b
`define SFFRD_OP_DUAL_OUT4 8'h3c
`define SFFRD_OP_QUAD_OUT 8'h6b
`define SFFRD_OP_QUAD_OUT4 8'h6c
`define SFFRD_OP_DUAL_IO 8'hbb

// ============================================================
// Dummy clock counts
`define SFFRD_DUMMY_FAST 5'h08
`define SFFRD_DUMMY_DTR 5'h06
`define SFFRD_DUMMY_DUAL_IO 5'h00
`define SFFRD_DUMMY_QPI_BASE 5'h02
`define SFFRD_DUMMY_QPI_DTR_MIN 5'h08

// ============================================================
// Field sizes and codes
`define SFFRD_CMD_BITS 6'h08
`define SFFRD_MODE_BITS 6'h08
`define SFFRD_ADDR_BITS_3B 6'h18
`define SFFRD_ADDR_BITS_4B 6'h20
`define SFFRD_BYTE_BITS 4'h8
`define SFFRD_MODE_BYPASS 2'h2
`define SFFRD_OE_X1 4'h2
`define SFFRD_OE_X2 4'h3
`define SFFRD_OE_X4 4'hf

`endif

// *** sffrd_pkg.sv ***
// Types of the serial flash fast read decoder
package sffrd_pkg;

  // ============================================================
  // Link state
  typedef enum logic [5:0] {
    LNK_CMD = 6'h01,
    LNK_ADDR = 6'h02,
    LNK_MODE = 6'h04,
    LNK_DUMMY = 6'h08,
    LNK_DATA = 6'h10,
    LNK_IGNORE = 6'h20
  } sffrd_link_state_type;

  typedef struct packed {
    logic [2:0] lanes_in;
    logic [2:0] lanes_out;
    logic ddr;
    logic aw32;
    logic has_mode;
    logic [4:0] dummy;
  } sffrd_op_type;

  typedef struct packed {
    logic valid;
    logic wrap;
    sffrd_op_type op;
  } sffrd_dec_type;

  typedef struct packed {
    logic quad_enable;
    logic quad_command_mode;
    logic four_byte;
    logic [7:0] ext_addr;
    logic [2:0] read_param;
    logic busy;
    logic rst_n;
  } sffrd_cfg_type;

  // ============================================================
  // State structs
  typedef struct packed {
    sffrd_link_state_type state;
    sffrd_op_type op;
    logic [5:0] cnt;
    logic [31:0] addr;
    logic [7:0] mode;
    logic [4:0] dummy;
    logic [7:0] byte_sr;
    logic [3:0] bits_left;
    logic ddr_active;
    logic [3:0] rise_out;
    logic [3:0] rise_oe;
    logic [3:0] fall_out;
    logic [3:0] fall_oe;
  } sffrd_xfer_type;

  typedef struct packed {
    logic cont;
    logic start_tgl;
    logic next_tgl;
    logic wrap_tgl;
    logic [31:0] addr_hold;
  } sffrd_pers_type;

  typedef struct packed {
    logic [3:0] io_out;
    logic [3:0] io_oe;
    logic [3:0] neg_in;
  } sffrd_fall_type;

  typedef struct packed {
    logic [2:0] tgl_seen;
    logic [31:0] mem_addr;
    logic mem_rd;
    logic cap;
    logic [7:0] data;
    logic wrap_pulse;
  } sffrd_sys_type;

endpackage : sffrd_pkg

// *** sffrd_sync.sv ***
// Two flip-flop level synchroniser
`timescale 1ns/1ps

module sffrd_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // ============================================================
  // Stages
  // No reset: the link clock may stand still, data only
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge i_clk)
  begin
    meta_ff <= i_async;
    sync_ff <= meta_ff;
  end

  assign o_sync = sync_ff;

endmodule : sffrd_sync

// *** sffrd_decoder_assertions.sv ***
// Concurrent checks on the fast read decoder ports
`timescale 1ns/1ps

module sffrd_decoder_assertions (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_quad_enable,
  input wire logic i_qpi_mode,
  input wire logic i_busy,
  input wire logic i_cs_n,
  input wire logic [3:0] o_io_oe,
  input wire logic o_mem_rd,
  input wire logic [31:0] o_mem_addr,
  input wire logic o_wrap_burst_cmd
);
  logic seen_ff;
  logic [31:0] last_ff;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  // ============================================================
  // Fetch tracking, cleared per frame since addresses restart
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || i_cs_n)
      seen_ff <= 1'b0;
    else if (o_mem_rd)
      seen_ff <= 1'b1;
    if (o_mem_rd)
      last_ff <= o_mem_addr;
  end

  // ============================================================
  // Assertions
  a_cs_release: assert property (i_cs_n |-> o_io_oe == 4'h0)
    else $error("io driven while chip select high");
  a_oe_lanes: assert property (o_io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal io enable pattern");
  a_quad_qe: assert property (o_io_oe == 4'hf |-> i_quad_enable)
    else $error("quad output without quad enable");
  a_rd_pulse: assert property (o_mem_rd |=> !o_mem_rd [*2])
    else $error("fetch pulse too long or too close");
  a_addr_hold: assert property (o_mem_rd |=> $stable(o_mem_addr))
    else $error("fetch address moved under fetch");
  a_addr_step: assert property (o_mem_rd && seen_ff && !i_cs_n |-> o_mem_addr == last_ff + 32'h1)
    else $error("fetch address did not step by one");
  a_wrap_qpi: assert property (o_wrap_burst_cmd |-> i_qpi_mode ##1 !o_wrap_burst_cmd)
    else $error("wrapped burst pulse outside quad command mode");
  a_busy_quiet: assert property (i_busy [*8] |-> !o_mem_rd && o_io_oe == 4'h0)
    else $error("read served while busy");

  c_wrap: cover property (o_wrap_burst_cmd);
  c_quad: cover property (o_io_oe == 4'hf);
  c_dual: cover property (o_io_oe == 4'h3);
endmodule : sffrd_decoder_assertions

bind sffrd_decoder sffrd_decoder_assertions sffrd_decoder_assertions_inst (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_quad_enable(i_quad_enable), .i_qpi_mode(i_qpi_mode),
  .i_busy(i_busy), .i_cs_n(i_cs_n), .o_io_oe(o_io_oe), .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr),
  .o_wrap_burst_cmd(o_wrap_burst_cmd)
);

// *** sffrd_host.sv ***
// SPI host model facing the decoder link
`timescale 1ns/1ps

module sffrd_host (
  output logic o_spi_clk,
  output logic o_cs_n,
  output logic [3:0] o_io,
  input wire logic [3:0] i_io_out,
  input wire logic [3:0] i_io_oe
);
  logic dat;
  int dln_r;
  logic [3:0] early_oe, data_oe;
  logic [31:0] sr;

  initial
  begin
    o_spi_clk = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'h0;
    dat = 1'b0;
  end

  // ============================================================
  // One link clock; released lines toggle so no stale value lingers
  // dummy samples feed only the enable check
  task automatic tick(input logic [3:0] v);
    o_io = v;
    #80;
    if (!dat)
      early_oe = early_oe | i_io_oe;
    else if (dln_r == 1)
      sr = {sr[30:0], i_io_out[1]};
    else
      for (int l = dln_r - 1; l >= 0; l--)
        sr = {sr[30:0], i_io_out[l]};
    if (dat)
      data_oe = i_io_oe;
    o_spi_clk = 1'b1;
    #80 o_spi_clk = 1'b0;
  endtask : tick

  task automatic send(input logic [31:0] v, input int n, input int ln);
    logic [3:0] w;
    for (int i = n - ln; i >= 0; i -= ln)
    begin
      w = ~o_io;
      for (int l = 0; l < ln; l++)
        w[l] = v[i + l];
      tick(w);
    end
  endtask : send

  // ============================================================
  // Whole read frame, four data bytes
  task automatic frame(input logic [7:0] op, input int oln, input logic [31:0] a, input int ab, input int aln,
    input int mb, input logic [7:0] m, input int dm, input int dln);
    early_oe = 4'h0;
    data_oe = 4'h0;
    dln_r = dln;
    o_cs_n = 1'b0;
    if (oln > 0)
      send({24'h0, op}, 8, oln);
    send(a, ab, aln);
    if (mb > 0)
      send({24'h0, m}, 8, aln);
    repeat (dm) tick(~o_io);
    dat = 1'b1;
    repeat (32 / dln) tick(~o_io);
    dat = 1'b0;
    o_cs_n = 1'b1;
    #160;
  endtask : frame

  task automatic abort(input logic [31:0] v, input int n);
    o_cs_n = 1'b0;
    send(v, n, 1);
    // Cut inside the data phase
    repeat (12) tick(~o_io);
    o_cs_n = 1'b1;
    #160;
  endtask : abort

  // Clocks with chip select high let config syncs settle
  task automatic settle();
    repeat (4) tick(~o_io);
  endtask : settle
endmodule : sffrd_host

// *** tb_top.sv ***
// Self-checking bench of the fast read decoder
`timescale 1ns/1ps

module tb_top;
  logic sys_clk, rst_n, qe, quad_command_mode, fourb, busy, mem_rd, wrap, spi_clk, cs_n, fresh;
  logic [2:0] param;
  logic [7:0] ext, mem_data;
  logic [31:0] mem_addr, first_addr;
  logic [3:0] io_in, io_out, io_oe;
  int failures, num_checks, n_rd, n_wrap;
  localparam logic [7:0] ops_tab [5] = '{8'h0c, 8'h3c, 8'h6c, 8'h3b, 8'h6b};
  localparam int ab_tab [5] = '{32, 32, 32, 24, 24};
  localparam int dl_tab [5] = '{1, 2, 4, 2, 4};
  localparam logic [3:0] oe_tab [5] = '{4'h2, 4'h3, 4'hf, 4'h3, 4'hf};

  sffrd_decoder sffrd_decoder_inst (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_quad_enable(qe), .i_qpi_mode(quad_command_mode), .i_four_byte_mode(fourb),
    .i_ext_addr(ext), .i_read_param(param), .i_busy(busy), .i_mem_data(mem_data), .o_mem_addr(mem_addr),
    .o_mem_rd(mem_rd), .o_wrap_burst_cmd(wrap), .i_spi_clk(spi_clk), .i_cs_n(cs_n), .i_io_in(io_in),
    .o_io_out(io_out), .o_io_oe(io_oe), .o_io_rise_out(), .o_io_rise_oe(), .o_ddr_active()
  );
  sffrd_host sffrd_host_inst (
    .o_spi_clk(spi_clk), .o_cs_n(cs_n), .o_io(io_in), .i_io_out(io_out), .i_io_oe(io_oe)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ============================================================
  // Memory array and fetch logging
  function automatic logic [7:0] mem_f(input logic [31:0] a);
    return a[31:24] ^ a[15:8] ^ a[7:0] ^ 8'h3c;
  endfunction : mem_f

  always @(negedge sys_clk) mem_data <= mem_f(mem_addr);
  always @(posedge sys_clk)
  begin
    fresh <= cs_n | (fresh & !mem_rd);
    if (wrap)
      n_wrap <= n_wrap + 1;
    if (mem_rd && !cs_n)
      n_rd <= n_rd + 1;
    if (mem_rd && !cs_n && fresh)
      first_addr <= mem_addr;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cfg(input logic q, input logic p, input logic f, input logic [2:0] rp, input logic b);
    @(negedge sys_clk);
    qe = q;
    quad_command_mode = p;
    fourb = f;
    param = rp;
    busy = b;
    #3;
    sffrd_host_inst.settle();
  endtask : cfg

  task automatic rd(input logic [7:0] op, input int oln, input logic [31:0] a, input int ab, input int aln,
    input int mb, input logic [7:0] m, input int dm, input int dln, input logic [3:0] oe);
    logic [31:0] ea;
    logic [31:0] e;
    int n0;
    ea = (ab == 32) ? a : {ext, a[23:0]};
    for (int i = 0; i < 4; i++)
      e = {e[23:0], mem_f(ea + i)};
    n0 = n_rd;
    sffrd_host_inst.frame(op, oln, a, ab, aln, mb, m, dm, dln);
    chk(sffrd_host_inst.early_oe, 4'h0);
    chk(sffrd_host_inst.data_oe, oe);
    if (oe == 4'h0)
      chk(n_rd - n0, 32'h0);
    else
    begin
      chk(first_addr, ea);
      chk(sffrd_host_inst.sr, e);
    end
  endtask : rd

  // ============================================================
  // Scenarios
  task automatic s_spi();
    rd(8'h0b, 1, 32'h0012fe, 24, 1, 0, 8'h0, 8, 1, 4'h2);
    cfg(1'b1, 1'b0, 1'b1, 3'h0, 1'b0);
    rd(8'h0b, 1, 32'h12345678, 32, 1, 0, 8'h0, 8, 1, 4'h2);
    cfg(1'b1, 1'b0, 1'b0, 3'h0, 1'b0);
    for (int k = 0; k < 5; k++)
      rd(ops_tab[k], 1, 32'h876543f0 + k, ab_tab[k], 1, 0, 8'h0, 8, dl_tab[k], oe_tab[k]);
  endtask : s_spi

  task automatic s_qe_off();
    cfg(1'b0, 1'b0, 1'b0, 3'h0, 1'b0);
    rd(8'h6b, 1, 32'h000100, 24, 1, 0, 8'h0, 8, 4, 4'h0);
    rd(8'h6c, 1, 32'h00000100, 32, 1, 0, 8'h0, 8, 4, 4'h0);
    cfg(1'b1, 1'b0, 1'b0, 3'h0, 1'b0);
  endtask : s_qe_off

  task automatic s_qpi();
    for (int p = 0; p < 8; p++)
    begin
      cfg(1'b1, 1'b1, 1'b0, p[2:0], 1'b0);
      rd(8'h0b, 4, 32'h000200 + p, 24, 4, 0, 8'h0, 2 * (p + 1), 4, 4'hf);
    end
    rd(8'h0c, 4, 32'h0, 24, 4, 0, 8'h0, 2, 4, 4'h0);
    chk(n_wrap, 32'h1);
    cfg(1'b1, 1'b0, 1'b0, 3'h0, 1'b0);
  endtask : s_qpi

  task automatic s_dual_io();
    rd(8'hbb, 1, 32'h00a0b0, 24, 2, 1, 8'ha5, 0, 2, 4'h3);
    rd(8'h00, 0, 32'h555555, 24, 2, 1, 8'h55, 0, 2, 4'h3);
    rd(8'hbb, 1, 32'h001000, 24, 2, 1, 8'h00, 0, 2, 4'h3);
  endtask : s_dual_io

  task automatic s_busy();
    cfg(1'b1, 1'b0, 1'b0, 3'h0, 1'b1);
    rd(8'h0b, 1, 32'h000300, 24, 1, 0, 8'h0, 8, 1, 4'h0);
    cfg(1'b1, 1'b0, 1'b0, 3'h0, 1'b0);
    sffrd_host_inst.abort(32'h0b000040, 32);
    chk(io_oe, 4'h0);
    rd(8'h0b, 1, 32'h000040, 24, 1, 0, 8'h0, 8, 1, 4'h2);
  endtask : s_busy

  task automatic end_sim();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  initial
  begin
    #600000;
    failures++;
    end_sim();
  end

  initial
  begin
    failures = 0;
    num_checks = 0;
    rst_n = 1'b0;
    {qe, quad_command_mode, fourb, busy} = 4'h8;
    param = 3'h0;
    ext = 8'ha5;
    repeat (20) @(negedge sys_clk);
    sffrd_host_inst.settle();
    rst_n = 1'b1;
    sffrd_host_inst.settle();
    s_spi();
    s_qe_off();
    s_qpi();
    s_dual_io();
    s_busy();
    end_sim();
  end
endmodule : tb_top
